// file: hdl/gpsr_pkg.sv
// package for the gpio stop recovery and drive configuration block
package gpsr_pkg;
    localparam int          GPSR_PORT_W    = 8;
    localparam logic [7:0]  GPSR_SEL_DRIVE = 8'h04;
    localparam logic [7:0]  GPSR_SEL_WAKE  = 8'h05;
    localparam logic [7:0]  GPSR_RST_DRIVE = 8'h00;
    localparam logic [7:0]  GPSR_RST_WAKE  = 8'h00;
    localparam logic [7:0]  GPSR_RST_SEL   = 8'h00;
    // glitch filter: least pulse width to pass, rounded up to whole cycles
    localparam int          GPSR_FILT_NS   = 10;
    localparam int          GPSR_CLK_NS    = 25;
    localparam int          GPSR_FILT_CYC_RAW =
        (GPSR_FILT_NS + GPSR_CLK_NS - 1) / GPSR_CLK_NS;
    localparam int          GPSR_FILT_CYC  =
        (GPSR_FILT_CYC_RAW < 1) ? 1 : GPSR_FILT_CYC_RAW;
    // default recovery delay in cycles
    localparam int          GPSR_RECOV_CYC = 16;

    // register access request from the cpu side
    typedef struct packed {
        logic       wr_addr;   // write to port address register
        logic       wr_ctrl;   // write to port control register
        logic [7:0] wdata;
    } gpsr_req_t;
endpackage : gpsr_pkg

// file: hdl/gpsr_port.sv
// gpio port logic: stop-mode wake-up, input capture and drive select
`timescale 1ns/1ps

module gpsr_port
    import gpsr_pkg::*;
#(
    parameter int WIDTH     = GPSR_PORT_W,
    parameter int RECOV_CYC = GPSR_RECOV_CYC
)(
    // clock, reset, enable
    input  wire logic             clock_in,
    input  wire logic             arst_n_in,
    input  wire logic             clk_en_in,
    // register access
    input  wire gpsr_req_t        req_in,
    output logic [7:0]            sel_rdata_out,
    output logic [7:0]            ctrl_rdata_out,
    // pins and mode
    input  wire logic [WIDTH-1:0] pin_in,
    input  wire logic             stop_mode_in,
    // status and drive
    output logic [WIDTH-1:0]      port_input_capture_out,
    output logic [WIDTH-1:0]      high_drive_en_out,
    output logic                  recovery_start_out,
    output logic                  wdt_stop_set_out,
    output logic                  recovering_out
);
    // refuse sizes the logic cannot serve: the write data is one byte
    if (WIDTH < 1 || WIDTH > 8)
    begin : g_bad_width
        $error("WIDTH must be 1 to 8");
    end
    if (RECOV_CYC < 1)
    begin : g_bad_recov
        $error("RECOV_CYC must be at least 1");
    end

    localparam int FW = $clog2(GPSR_FILT_CYC + 1);
    localparam int RW = $clog2(RECOV_CYC + 1);

    typedef enum logic [1:0] {GPSR_RUN, GPSR_STOP, GPSR_RECOV} gpsr_state_t;

    gpsr_state_t      state_q, state_d;
    logic [7:0]       sel_q;
    logic [WIDTH-1:0] high_drive_en_q;
    logic [WIDTH-1:0] wake_source_en_q;
    logic [WIDTH-1:0] capture_q;
    logic [WIDTH-1:0] ref_q;
    logic [WIDTH-1:0] filt_q;
    logic [FW-1:0]    filt_cnt_q [WIDTH];
    logic [RW-1:0]    recov_cnt_q;
    logic             start_q;
    logic             stop_set_q;
    logic [7:0]       ctrl_rd_q;
    logic             recovering_q;

    // sub-register decode, reused for writes and reads
    function automatic logic sel_is(input logic [7:0] s, input logic [7:0] v);
        return s == v;
    endfunction : sel_is

    wire logic hit_drive = sel_is(sel_q, GPSR_SEL_DRIVE);
    wire logic hit_wake  = sel_is(sel_q, GPSR_SEL_WAKE);
    wire logic wr_drive  = clk_en_in & req_in.wr_ctrl & hit_drive;
    wire logic wr_wake   = clk_en_in & req_in.wr_ctrl & hit_wake;
    wire logic [7:0] drive_ext = 8'(high_drive_en_q);
    wire logic [7:0] wake_ext  = 8'(wake_source_en_q);
    wire logic [7:0] ctrl_rd_d = hit_drive ? drive_ext :
                                 hit_wake  ? wake_ext  : 8'h00;

    // a filtered level differing from the stop-entry reference wakes us
    wire logic [WIDTH-1:0] wake_hit = (filt_q ^ ref_q) & wake_source_en_q;
    wire logic trig = (state_q == GPSR_STOP) && (|wake_hit);
    wire logic recov_done = (state_q == GPSR_RECOV) &&
                            (recov_cnt_q == RW'(RECOV_CYC - 1));
    wire logic [RW-1:0] recov_cnt_d = (state_q == GPSR_RECOV) ?
                                      recov_cnt_q + 1'b1 : '0;
    // capture loads in run and once at the end of the delay
    wire logic cap_load = (state_q == GPSR_RUN) || recov_done;

    // mode sequencing
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            GPSR_RUN:   if (stop_mode_in) state_d = GPSR_STOP;
            GPSR_STOP:  if (trig) state_d = GPSR_RECOV;
                        else if (!stop_mode_in) state_d = GPSR_RUN;
            GPSR_RECOV: if (recov_done) state_d = GPSR_RUN;
            default:    state_d = GPSR_RUN;  // unused code falls back to run
        endcase
    end

    // per-pin glitch filter: a new level must hold GPSR_FILT_CYC cycles
    // pins are taken as synchronous, so one stable sample is a full cycle,
    // already longer than the shortest pulse that must be rejected
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_filt
        always_ff @(posedge clock_in or negedge arst_n_in)
        begin
            if (!arst_n_in)
            begin
                filt_q[i]     <= 1'b0;
                filt_cnt_q[i] <= '0;
            end
            else if (clk_en_in)
            begin
                if (pin_in[i] == filt_q[i])
                    filt_cnt_q[i] <= '0;
                else if (filt_cnt_q[i] == FW'(GPSR_FILT_CYC - 1))
                begin
                    filt_q[i]     <= pin_in[i];
                    filt_cnt_q[i] <= '0;
                end
                else
                    filt_cnt_q[i] <= filt_cnt_q[i] + 1'b1;
            end
        end
    end

    // selector register, separate per instance of this port
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            sel_q <= GPSR_RST_SEL;
        else if (clk_en_in && req_in.wr_addr)
            sel_q <= req_in.wdata;
    end

    // drive bits: a write beside a new selector still uses the old one
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            high_drive_en_q <= WIDTH'(GPSR_RST_DRIVE);
        else if (wr_drive)
            high_drive_en_q <= req_in.wdata[WIDTH-1:0];
    end

    // wake source bits; a pin left at 0 can never wake the port
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            wake_source_en_q <= WIDTH'(GPSR_RST_WAKE);
        else if (wr_wake)
            wake_source_en_q <= req_in.wdata[WIDTH-1:0];
    end

    // read view kept in a flop, so it trails the selector by one cycle
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            ctrl_rd_q <= '0;
        else if (clk_en_in)
            ctrl_rd_q <= ctrl_rd_d;
    end

    // mode state, recovery level and the one-cycle start and flag pulses
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_q      <= GPSR_RUN;
            recovering_q <= 1'b0;
            start_q      <= 1'b0;
            stop_set_q   <= 1'b0;
        end
        else if (clk_en_in)
        begin
            state_q      <= state_d;
            recovering_q <= (state_d == GPSR_RECOV);
            start_q      <= trig;
            stop_set_q   <= trig;
        end
    end

    // recovery delay counter, cleared whenever we are not recovering
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            recov_cnt_q <= '0;
        else if (clk_en_in)
            recov_cnt_q <= recov_cnt_d;
    end

    // capture is frozen outside run, only levels still present
    // at the end of the delay land, so a short wake pulse is lost
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            capture_q <= '0;
            ref_q     <= '0;
        end
        else if (clk_en_in)
        begin
            if (cap_load)
                capture_q <= pin_in;
            if (state_q == GPSR_RUN)
                ref_q <= filt_q;
        end
    end

    assign sel_rdata_out          = sel_q;
    assign ctrl_rdata_out         = ctrl_rd_q;
    assign port_input_capture_out = capture_q;
    assign high_drive_en_out      = high_drive_en_q;
    assign recovery_start_out     = start_q;
    assign wdt_stop_set_out       = stop_set_q;
    assign recovering_out         = recovering_q;
endmodule : gpsr_port

// file: tb/gpsr_pin_model.sv
// pin driver model: steady levels plus short glitches
`timescale 1ns/1ps
module gpsr_pin_model (
    input  wire logic       clock_in,
    input  wire logic [7:0] level_in,
    input  wire logic [7:0] glitch_in,
    output logic      [7:0] pin_out
);
    initial pin_out = 8'h00;
    // glitch lasts 5 ns mid-cycle, so it never straddles a sampling edge
    always @(negedge clock_in)
    begin
        pin_out = level_in ^ glitch_in;
        #5 pin_out = level_in;
    end
endmodule : gpsr_pin_model

// file: tb/gpsr_port_assertions.sv
// concurrent checks on the gpio stop recovery port
`timescale 1ns/1ps
module gpsr_port_assertions
    import gpsr_pkg::*;
(
    input wire logic       clock_in, arst_n_in, clk_en_in, stop_mode_in,
    input wire gpsr_req_t  req_in,
    input wire logic [7:0] sel_rdata_out, ctrl_rdata_out, high_drive_en_out,
    input wire logic [7:0] port_input_capture_out,
    input wire logic       recovery_start_out, wdt_stop_set_out, recovering_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    // a start must lead straight into the recovery delay
    sequence s_delay; recovery_start_out ##[0:1] recovering_out; endsequence
    wire logic sel_d = clk_en_in && sel_rdata_out == GPSR_SEL_DRIVE;
    wire logic sel_x = sel_rdata_out != GPSR_SEL_DRIVE &&
                       sel_rdata_out != GPSR_SEL_WAKE;
    a_sel_write: assert property (
        clk_en_in && req_in.wr_addr |=>
        sel_rdata_out == $past(req_in.wdata)) else $error("sel lost");
    a_drive_write: assert property (sel_d && req_in.wr_ctrl |=>
        high_drive_en_out == $past(req_in.wdata)) else $error("drive lost");
    a_drive_view: assert property (sel_d |=>
        ctrl_rdata_out == $past(high_drive_en_out)) else $error("bad view");
    a_idle_view: assert property (clk_en_in && sel_x |=>
        ctrl_rdata_out == 8'h00) else $error("unmapped view");
    a_flag_start: assert property (recovery_start_out |->
        wdt_stop_set_out) else $error("flag missing");
    a_start_delay: assert property (recovery_start_out |->
        s_delay) else $error("no delay");
    a_start_stop: assert property (recovery_start_out |->
        $past(stop_mode_in)) else $error("wake outside stop");
    a_capture_held: assert property (recovering_out &&
        $past(recovering_out) |-> $stable(port_input_capture_out))
        else $error("capture moved");
endmodule : gpsr_port_assertions

bind gpsr_port gpsr_port_assertions u_chk (.clock_in, .arst_n_in, .clk_en_in,
    .stop_mode_in, .req_in, .sel_rdata_out, .ctrl_rdata_out,
    .high_drive_en_out, .port_input_capture_out, .recovery_start_out,
    .wdt_stop_set_out, .recovering_out);

// file: tb/gpsr_port_test.sv
// self-checking bench for the gpio stop recovery port
`timescale 1ns/1ps
module gpsr_port_test;
    import gpsr_pkg::*;
    logic       clock_in = 1'b0, arst_n_in = 1'b0, stop_mode_in = 1'b0, seen;
    logic       clk_en_in = 1'b1;
    gpsr_req_t  req_in = '0;
    logic [7:0] lvl = 8'h00, gl = 8'h00, pin_in, sel_rdata_out, ctrl_rdata_out;
    logic [7:0] port_input_capture_out, high_drive_en_out;
    logic       recovery_start_out, wdt_stop_set_out, recovering_out;
    int         n_errors = 0, n_tests = 0, n_rec = 0;
    gpsr_pin_model pins (.clock_in, .level_in(lvl), .glitch_in(gl),
        .pin_out(pin_in));
    // a short recovery delay keeps the wake scenarios brief
    localparam int RECOV = 2;
    gpsr_port #(.RECOV_CYC(RECOV)) dut (.clock_in, .arst_n_in, .clk_en_in,
        .req_in, .sel_rdata_out, .ctrl_rdata_out, .pin_in, .stop_mode_in,
        .port_input_capture_out, .high_drive_en_out, .recovery_start_out,
        .wdt_stop_set_out, .recovering_out);
    initial forever #12.5 clock_in = ~clock_in;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic a, input logic c, input logic [7:0] d);
        @(posedge clock_in) req_in <= '{a, c, d};
        @(posedge clock_in) req_in <= '0;
        repeat (2) @(negedge clock_in);
    endtask : wr
    // watch n cycles; every start must carry the watchdog flag
    task watch(input int n);
        seen = 1'b0;
        n_rec = 0;
        repeat (n) @(negedge clock_in)
        begin
            if (recovering_out === 1'b1) n_rec++;
            if (recovery_start_out === 1'b1)
            begin
                seen = 1'b1;
                chk({7'h0, wdt_stop_set_out}, 8'h01);
            end
        end
    endtask : watch
    task t_regs;
        chk(high_drive_en_out, 8'h00);
        wr(1'b1, 1'b0, GPSR_SEL_WAKE);
        chk(ctrl_rdata_out, 8'h00);
        wr(1'b1, 1'b0, GPSR_SEL_DRIVE);
        wr(1'b0, 1'b1, 8'hA5);
        chk(high_drive_en_out, 8'hA5);
        chk(ctrl_rdata_out, 8'hA5);
        wr(1'b1, 1'b1, 8'h3C); // same cycle: data goes to the old selector
        chk(high_drive_en_out, 8'h3C);
        chk(ctrl_rdata_out, 8'h00);
        wr(1'b1, 1'b0, GPSR_SEL_WAKE);
        wr(1'b0, 1'b1, 8'h01);
        chk(ctrl_rdata_out, 8'h01);
        wr(1'b1, 1'b0, 8'h06);
        wr(1'b0, 1'b1, 8'hFF);
        chk(high_drive_en_out, 8'h3C);
        $display("regs test done");
    endtask : t_regs
    task t_wake;
        @(posedge clock_in) stop_mode_in <= 1'b1;
        @(posedge clock_in) gl <= 8'h01;
        @(posedge clock_in) gl <= 8'h00;
        watch(4);
        chk({7'h0, seen}, 8'h00);
        @(posedge clock_in) lvl <= 8'h02;
        watch(4);
        chk({7'h0, seen}, 8'h00);
        chk(port_input_capture_out, 8'h00);
        @(posedge clock_in) lvl <= 8'h03;
        watch(10);
        chk({7'h0, seen}, 8'h01);
        chk(port_input_capture_out, 8'h03);
        chk(8'(n_rec), 8'(RECOV));
        // one-cycle dip on a wake pin: it wakes, but is gone at the end
        @(posedge clock_in) lvl <= 8'h02;
        @(posedge clock_in) lvl <= 8'h03;
        watch(6);
        chk({7'h0, seen}, 8'h01);
        chk(port_input_capture_out, 8'h03);
        @(posedge clock_in) stop_mode_in <= 1'b0;
        $display("wake test done");
    endtask : t_wake
    // with the enable low a write must leave every register alone
    task t_freeze;
        @(posedge clock_in) clk_en_in <= 1'b0;
        wr(1'b1, 1'b1, GPSR_SEL_DRIVE);
        chk(sel_rdata_out, 8'h06);
        chk(high_drive_en_out, 8'h3C);
        @(posedge clock_in) clk_en_in <= 1'b1;
        $display("freeze test done");
    endtask : t_freeze
    task complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    initial
    begin
        repeat (10) @(posedge clock_in);
        arst_n_in <= 1'b1;
        t_regs;
        t_wake;
        t_freeze;
        complete_run;
    end
endmodule : gpsr_port_test
